// [host_model.sv]
// host-side model: pin pull-ups, clock edge count, watchdog service
`timescale 1ns/1ps

module host_model (
  input  wire       clk,             // main clock
  input  wire       hostResetOe,     // reset pin pulled low
  input  wire       warnOe,          // warning pin pulled low
  input  wire       hostClockOutput, // clock from device
  output wire       hostResetN,      // resolved reset pin
  output wire       powerFailWarnN,  // resolved warning pin
  output reg [15:0] hostEdges,       // host clock rising edges
  output reg  [7:0] warnEvents,      // warning falls seen
  output reg        wdWrite,         // watchdog register write
  output reg        wdEnableData,    // written enable
  output reg  [3:0] wdTimeoutSelect  // written select
);
  // released pins float up to the pull-up level
  assign hostResetN = hostResetOe ? 1'b0 : 1'b1;
  assign powerFailWarnN = warnOe ? 1'b0 : 1'b1;

  initial begin
    {hostEdges, warnEvents} = 24'h000000;
    {wdWrite, wdEnableData, wdTimeoutSelect} = 6'h00;
  end

  always @(posedge hostClockOutput) hostEdges <= hostEdges + 16'h0001;
  // each warning fall adds one to warnEvents
  always @(negedge powerFailWarnN) warnEvents <= warnEvents + 8'h01;

  task service(input logic en, input logic [3:0] sel);
    @(negedge clk);
    {wdWrite, wdEnableData, wdTimeoutSelect} = {1'b1, en, sel};
    @(negedge clk);
    wdWrite = 1'b0;
  endtask
endmodule

// [supervisor_clock_watchdog.v]
// supervisor: host clock, transmit marker, reset/warning, states, watchdog
//
// Notes on behaviour
// - all timing derives from one main clock; crystal or external source selectable.
// - clearing the host clock enable stops the host clock output.
// - in Stand-By after power-up the host clock is the slow 4 MHz clock.
// - in Normal the host clock is 8 MHz, or 16 MHz with strap high.
// - leaving Normal for Stand-By keeps the fast clock unless an oscillator fault caused it.
// - marker rises one bit time before a scheduled frame; falls on done/collision.
// - unscheduled frames and responses start in the same cycle that the marker rises.
// - host reset held low while filter, fixed supply or thermal shutdown state is bad.
// - warning low at once on filter below 14 V; after 2 ms on bus low.
// - host reset low when filter capacitor is below 12 V.
// - reset and warning pins only pull low; a pull-up returns them high.
// - bus, filter, adjustable and 20 V supervisor states are readable status.
// - Stand-By from Start-Up: oscillator off, then on after a short delay, slow clock, host on, bus off.
// - Stand-By from Normal keeps supplies on unless a supply caused it.
// - in Stand-By bus traffic is off except when partly allowed.
// - thermal warning pulls the warning pin and sets a readable status bit.
// - thermal shutdown forces Reset, latches status and stops supplies.
// - after cooling go Start-Up then Stand-By; Normal once all is good.
// - warning bit follows temperature; shutdown bit clears on read when cool.
// - host rewrites the watchdog enable before timeout; each rewrite clears timer.
// - early service or missed timeout pulls the host reset low.
// - timeout select sets 33..524 ms timeout and 2..31 ms least period.
// - Normal and warning release need oscillator, no thermal, all supplies good.
// - bus low past the filter time clears bus status, Stand-By, warning.
`timescale 1ns/1ps
`include "supervisor_clock_watchdog_consts.vh"

module supervisor_clock_watchdog #(
  parameter MS_CYC  = `MS_CYCLES,   // cycles per millisecond
  parameter BIT_CYC = `BIT_CYCLES   // cycles per bus bit
) (
  input  wire       clk,              // 250 MHz main clock
  input  wire       sys_rst,          // async reset, active high
  input  wire       clockSourceSelect, // 1 external generator, 0 crystal
  input  wire       xtalRunning,      // crystal oscillator running
  input  wire       extClkRunning,    // external generator running
  input  wire       hostClockOutputEnable, // host clock enable bit
  input  wire       hostClockRateStrap, // 0 8 MHz, 1 16 MHz
  input  wire       busVoltageOk,     // bus above low threshold
  input  wire       filterAbove14V,   // filter capacitor above 14 V
  input  wire       filterCapVoltageOk, // filter capacitor above 12 V
  input  wire       fixedSupplyOk,    // fixed converter started
  input  wire       adjustableSupplyOk, // adjustable supply good
  input  wire       twentyVoltSupplyOk, // 20 V supply good
  input  wire       thermalWarning,   // above warning temperature
  input  wire       thermalShutdown,  // above shutdown temperature
  input  wire       shutdownRead,     // pulse: host reads shutdown bit
  input  wire       busPartialAllow,  // stand-by partial bus activity
  input  wire       triggerEnable,    // control register bit 3
  input  wire       txRequest,        // pulse: frame ready to send
  input  wire       txScheduled,      // frame sent within bus-idle time
  input  wire       txDone,           // pulse: transmission complete
  input  wire       txCollision,      // pulse: collision seen
  input  wire       wdWrite,          // pulse: watchdog register write
  input  wire       wdEnableData,     // written enable value
  input  wire [3:0] wdTimeoutSelect,  // written timeout select
  output reg        hostClockOutput,  // clock to host
  output reg        transmitMarkerOut, // transmit trigger pin
  output reg        txGo,             // pulse: start transmission
  output wire       hostResetOut,     // reset pin drive level
  output wire       hostResetOe,      // reset pin pulled low when high
  output wire       warnOut,          // warning pin drive level
  output wire       warnOe,           // warning pin pulled low when high
  output wire       busOkStatus,      // bus supervisor status
  output wire       filterOkStatus,   // filter supervisor status
  output wire       adjOkStatus,      // adjustable supply status
  output wire       v20OkStatus,      // 20 V supply status
  output wire       oscStatus,        // oscillator running status
  output wire       thermalWarnStatus, // thermal warning status
  output reg        shutdownLatched,  // latched thermal shutdown
  output wire [3:0] stateOut,         // one-hot analog state
  output reg        oscEnable,        // oscillator enable
  output wire       fixedSupplyEnable, // fixed converter enable
  output wire       auxSupplyEnable,  // adjustable and 20 V enable
  output wire       hostIfActive,     // host interface active
  output wire       busCommActive,    // bus communication active
  output reg        wdEnabled         // watchdog running
);

  localparam [3:0] ST_RESET   = 4'h1;
  localparam [3:0] ST_STARTUP = 4'h2;
  localparam [3:0] ST_STANDBY = 4'h4;
  localparam [3:0] ST_NORMAL  = 4'h8;

  localparam [63:0] STEP4  = `STEP(`F4_HZ);
  localparam [63:0] STEP8  = `STEP(`F8_HZ);
  localparam [63:0] STEP16 = `STEP(`F16_HZ);

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [17:0] msDiv_q;
  reg         fromNormal_q;
  reg         xtalCause_q;
  reg         supplyCause_q;
  reg  [9:0]  busLowMs_q;
  reg  [9:0]  oscDelayMs_q;
  reg  [31:0] phase_q;
  reg  [31:0] step;
  reg  [1:0]  clkSel;
  reg  [31:0] bitCnt_q;
  reg         leadWait_q;
  reg  [9:0]  wdMs_q;
  reg  [3:0]  wdSel_q;
  reg  [7:0]  wdPulse_q;
  reg  [9:0]  wdTimeout;
  reg  [9:0]  wdMin;

  wire msTick   = (msDiv_q == MS_CYC[17:0] - 18'h00001);
  wire oscOk    = clockSourceSelect ? extClkRunning : xtalRunning;
  wire busOk    = (busLowMs_q < `BUS_QUAL_MS);
  wire allGood  = oscOk & ~thermalWarning & ~thermalShutdown &
                  busOk & filterCapVoltageOk &
                  adjustableSupplyOk & twentyVoltSupplyOk;
  wire stResetN = ~thermalShutdown & filterCapVoltageOk;
  wire wdFire   = (wdPulse_q != 8'h00);

  assign stateOut          = state_q;
  assign busOkStatus       = busOk;
  assign filterOkStatus    = filterCapVoltageOk;
  assign adjOkStatus       = adjustableSupplyOk;
  assign v20OkStatus       = twentyVoltSupplyOk;
  assign oscStatus         = oscOk & oscEnable;
  assign thermalWarnStatus = thermalWarning;
  assign fixedSupplyEnable = ~state_q[0];
  assign auxSupplyEnable   = (state_q[2] | state_q[3]) & filterCapVoltageOk &
                             ~(fromNormal_q & supplyCause_q);
  assign hostIfActive      = state_q[2] | state_q[3];
  assign busCommActive     = state_q[3] |
                             (state_q[2] & busPartialAllow);

  // open-drain pins: drive level is always low
  assign hostResetOut = 1'b0;
  assign warnOut      = 1'b0;
  assign hostResetOe  = state_q[0] | state_q[1] | ~fixedSupplyOk |
                        ~filterCapVoltageOk | thermalShutdown |
                        wdFire;
  assign warnOe       = ~state_q[3] | ~filterAbove14V |
                        thermalWarning;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (stResetN) begin
          state_d = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (!stResetN) begin
          state_d = ST_RESET;
        end else if (fixedSupplyOk) begin
          state_d = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (!stResetN || !fixedSupplyOk) begin
          state_d = ST_RESET;
        end else if (allGood && oscEnable) begin
          state_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (!stResetN || !fixedSupplyOk) begin
          state_d = ST_RESET;
        end else if (!allGood) begin
          state_d = ST_STANDBY;
        end
      end
      default: state_d = ST_RESET;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q       <= ST_RESET;
      msDiv_q       <= 18'h00000;
      fromNormal_q  <= 1'b0;
      xtalCause_q   <= 1'b0;
      supplyCause_q <= 1'b0;
      busLowMs_q    <= 10'h000;
      oscDelayMs_q  <= 10'h000;
      oscEnable     <= 1'b0;
    end else begin
      state_q <= state_d;
      msDiv_q <= msTick ? 18'h00000 : msDiv_q + 18'h00001;
      if (busVoltageOk) begin
        busLowMs_q <= 10'h000;
      end else if (msTick && busLowMs_q < `BUS_QUAL_MS) begin
        busLowMs_q <= busLowMs_q + 10'h001;
      end
      if (state_q[3] && state_d[2]) begin
        fromNormal_q  <= 1'b1;
        xtalCause_q   <= ~oscOk;
        supplyCause_q <= ~adjustableSupplyOk |
                         ~twentyVoltSupplyOk;
      end else if (state_d[0] || state_d[1]) begin
        fromNormal_q  <= 1'b0;
        xtalCause_q   <= 1'b0;
        supplyCause_q <= 1'b0;
      end
      // oscillator starts a short delay after Stand-By entry
      if (!(state_q[2] || state_q[3])) begin
        oscDelayMs_q <= 10'h000;
        oscEnable    <= 1'b0;
      end else if (oscDelayMs_q >= `OSC_DELAY_MS) begin
        oscEnable    <= 1'b1;
      end else if (msTick) begin
        oscDelayMs_q <= oscDelayMs_q + 10'h001;
      end
    end
  end

  // shutdown flag: set wins over the read clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shutdownLatched <= 1'b0;
    end else if (thermalShutdown) begin
      shutdownLatched <= 1'b1;
    end else if (shutdownRead) begin
      shutdownLatched <= 1'b0;
    end
  end

  // host clock select and phase accumulator
  always @* begin
    clkSel = `HCLK_OFF;
    if (!hostClockOutputEnable) begin
      clkSel = `HCLK_OFF;
    end else if (state_q[3]) begin
      clkSel = `HCLK_FAST;
    end else if (state_q[2]) begin
      clkSel = (fromNormal_q && !xtalCause_q) ?
               `HCLK_FAST : `HCLK_SLOW;
    end
    case (clkSel)
      `HCLK_SLOW: step = STEP4[31:0];
      `HCLK_FAST: step = hostClockRateStrap ?
                         STEP16[31:0] : STEP8[31:0];
      default:    step = 32'h00000000;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q         <= 32'h00000000;
      hostClockOutput <= 1'b0;
    end else if (clkSel == `HCLK_OFF) begin
      phase_q         <= 32'h00000000;
      hostClockOutput <= 1'b0;
    end else begin
      phase_q         <= phase_q + step;
      hostClockOutput <= phase_q[31];
    end
  end

  // transmit marker: lead of one bit for scheduled frames
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      transmitMarkerOut <= 1'b0;
      txGo              <= 1'b0;
      leadWait_q        <= 1'b0;
      bitCnt_q          <= 32'h00000000;
    end else begin
      txGo <= 1'b0;
      if (txDone || txCollision) begin
        transmitMarkerOut <= 1'b0;
        leadWait_q        <= 1'b0;
      end else if (txRequest && !transmitMarkerOut) begin
        transmitMarkerOut <= triggerEnable;
        leadWait_q        <= txScheduled;
        bitCnt_q          <= 32'h00000001;
        txGo              <= ~txScheduled;
      end else if (leadWait_q) begin
        bitCnt_q <= bitCnt_q + 32'h00000001;
        if (bitCnt_q == BIT_CYC) begin
          txGo       <= 1'b1;
          leadWait_q <= 1'b0;
        end
      end
    end
  end

  // watchdog timing table in ms
  always @* begin
    case (wdSel_q)
      4'h0: begin wdTimeout = 10'd33;  wdMin = 10'd2;  end
      4'h1: begin wdTimeout = 10'd66;  wdMin = 10'd4;  end
      4'h2: begin wdTimeout = 10'd98;  wdMin = 10'd6;  end
      4'h3: begin wdTimeout = 10'd131; wdMin = 10'd8;  end
      4'h4: begin wdTimeout = 10'd164; wdMin = 10'd10; end
      4'h5: begin wdTimeout = 10'd197; wdMin = 10'd12; end
      4'h6: begin wdTimeout = 10'd229; wdMin = 10'd14; end
      4'h7: begin wdTimeout = 10'd262; wdMin = 10'd16; end
      4'h8: begin wdTimeout = 10'd295; wdMin = 10'd18; end
      4'h9: begin wdTimeout = 10'd328; wdMin = 10'd20; end
      4'hA: begin wdTimeout = 10'd360; wdMin = 10'd23; end
      4'hB: begin wdTimeout = 10'd393; wdMin = 10'd25; end
      4'hC: begin wdTimeout = 10'd426; wdMin = 10'd27; end
      4'hD: begin wdTimeout = 10'd459; wdMin = 10'd29; end
      4'hE: begin wdTimeout = 10'd492; wdMin = 10'd30; end
      default: begin wdTimeout = 10'd524; wdMin = 10'd31; end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdEnabled <= 1'b0;
      wdSel_q   <= `WD_SEL_RST;
      wdMs_q    <= 10'h000;
      wdPulse_q <= 8'h00;
    end else begin
      if (wdFire) begin
        wdPulse_q <= wdPulse_q - 8'h01;
        wdMs_q    <= 10'h000;
      end else if (wdWrite) begin
        wdSel_q   <= wdTimeoutSelect;
        wdEnabled <= wdEnableData;
        wdMs_q    <= 10'h000;
        if (wdEnabled && wdEnableData && wdMs_q < wdMin) begin
          wdPulse_q <= `WD_PULSE_CYC;
        end
      end else if (wdEnabled) begin
        if (wdMs_q >= wdTimeout) begin
          wdPulse_q <= `WD_PULSE_CYC;
        end else if (msTick) begin
          wdMs_q <= wdMs_q + 10'h001;
        end
      end
    end
  end

endmodule

// [supervisor_clock_watchdog_bench.sv]
// self-checking bench of the supervisor, clock and watchdog block
`timescale 1ns/1ps
`include "supervisor_clock_watchdog_consts.vh"

module supervisor_clock_watchdog_bench;
  localparam int BT = 20;
  logic clk, sys_rst, clockSourceSelect, xtalRunning, extClkRunning;
  logic hostClockOutputEnable, hostClockRateStrap, busVoltageOk;
  logic filterAbove14V, filterCapVoltageOk, fixedSupplyOk, busPartialAllow;
  logic adjustableSupplyOk, twentyVoltSupplyOk, thermalWarning;
  logic thermalShutdown, shutdownRead, triggerEnable, txRequest;
  logic txScheduled, txDone, txCollision;
  wire wdWrite, wdEnableData, hostClockOutput, transmitMarkerOut, txGo;
  wire hostResetOut, hostResetOe, warnOut, warnOe, busOkStatus;
  wire filterOkStatus, adjOkStatus, v20OkStatus, oscStatus, oscEnable;
  wire thermalWarnStatus, shutdownLatched, fixedSupplyEnable, wdEnabled;
  wire auxSupplyEnable, hostIfActive, busCommActive;
  wire hostResetN, powerFailWarnN;
  wire [3:0] wdTimeoutSelect, stateOut;
  wire [15:0] hostEdges;
  wire [7:0] warnEvents;
  int errors, num_checks, cyc;

  supervisor_clock_watchdog #(.MS_CYC(100), .BIT_CYC(BT)) dut (.*);
  host_model host (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task waitst(input logic [3:0] s, input int lim);
    int i;
    for (i = 0; i < lim && stateOut !== s; i++)
      @(negedge clk);
    chk(8'(stateOut), 8'(s));
  endtask

  // host clock edges in 640 ns: 4 MHz gives 2, 8 gives 5, 16 gives 10
  task freq(input int e);
    int a;
    a = hostEdges;
    step(160);
    a = hostEdges - a;
    chk(8'(a >= e && a <= e + 1), 8'h01);
  endtask

  task t_power;
    waitst(4'h2, 5);
    chk(8'(hostResetOe), 8'h01);
    fixedSupplyOk = 1'b1;
    waitst(4'h4, 5);
    chk(8'({hostResetOe, warnOe, hostIfActive, busCommActive, oscEnable}),
        8'h0C);
    freq(2);
    waitst(4'h8, 300);
    chk(8'(warnOe), 8'h00);
    freq(5);
    hostClockRateStrap = 1'b1;
    step(2);
    freq(10);
    hostClockOutputEnable = 1'b0;
    step(2);
    freq(0);
    hostClockOutputEnable = 1'b1;
    $display("power-up test done");
  endtask

  task t_marker;
    int n;
    {triggerEnable, txScheduled, txRequest} = 3'b111;
    step(1);
    txRequest = 1'b0;
    chk(8'({transmitMarkerOut, txGo}), 8'h02);
    n = 0;
    while (txGo !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    chk(8'(n), 8'(BT));
    step(1);
    chk(8'(txGo), 8'h00);
    txDone = 1'b1;
    step(1);
    txDone = 1'b0;
    chk(8'(transmitMarkerOut), 8'h00);
    {txScheduled, txRequest} = 2'b01;
    step(1);
    txRequest = 1'b0;
    chk(8'({transmitMarkerOut, txGo}), 8'h03);
    txCollision = 1'b1;
    step(1);
    txCollision = 1'b0;
    chk(8'(transmitMarkerOut), 8'h00);
    {triggerEnable, txScheduled, txRequest} = 3'b011;
    step(1);
    txRequest = 1'b0;
    chk(8'(transmitMarkerOut), 8'h00);
    step(BT + 2);
    $display("marker test done");
  endtask

  task t_warn;
    int n;
    filterAbove14V = 1'b0;
    #1;
    chk(8'(warnOe), 8'h01);
    step(1);
    {filterAbove14V, busVoltageOk} = 2'b10;
    n = 0;
    while (busOkStatus !== 1'b0 && n < 300) begin
      step(1);
      n++;
    end
    chk(8'(n >= 99 && n <= 202), 8'h01);
    step(1);
    chk(8'({stateOut, warnOe, auxSupplyEnable}), 8'h13);
    freq(10);
    chk(8'(busCommActive), 8'h00);
    busPartialAllow = 1'b1;
    #1;
    chk(8'(busCommActive), 8'h01);
    {busPartialAllow, busVoltageOk} = 2'b01;
    waitst(4'h8, 300);
    xtalRunning = 1'b0;
    step(2);
    chk(8'({stateOut, oscStatus}), 8'h08);
    freq(2);
    {clockSourceSelect, extClkRunning} = 2'b11;
    waitst(4'h8, 300);
    adjustableSupplyOk = 1'b0;
    step(2);
    chk(8'({stateOut, auxSupplyEnable}), 8'h08);
    adjustableSupplyOk = 1'b1;
    waitst(4'h8, 300);
    $display("warning test done");
  endtask

  task t_thermal;
    logic [7:0] w;
    w = warnEvents;
    thermalWarning = 1'b1;
    #1;
    chk(8'({warnOe, thermalWarnStatus}), 8'h03);
    step(2);
    chk(8'(stateOut), 8'h04);
    chk(warnEvents - w, 8'h01);
    thermalShutdown = 1'b1;
    step(20);
    chk(8'({stateOut, shutdownLatched, hostResetOe, fixedSupplyEnable}),
        8'h0E);
    shutdownRead = 1'b1;
    step(1);
    {shutdownRead, thermalShutdown} = 2'b00;
    chk(8'(shutdownLatched), 8'h01);
    waitst(4'h2, 5);
    waitst(4'h4, 5);
    chk(8'(hostResetOe), 8'h00);
    shutdownRead = 1'b1;
    step(1);
    shutdownRead = 1'b0;
    chk(8'(shutdownLatched), 8'h00);
    thermalWarning = 1'b0;
    #1;
    chk(8'(thermalWarnStatus), 8'h00);
    waitst(4'h8, 300);
    chk(8'(warnOe), 8'h00);
    $display("thermal test done");
  endtask

  task t_supply;
    filterCapVoltageOk = 1'b0;
    #1;
    chk(8'({hostResetOe, filterOkStatus}), 8'h02);
    step(2);
    chk(8'(stateOut), 8'h01);
    {filterCapVoltageOk, fixedSupplyOk} = 2'b10;
    #1;
    chk(8'(hostResetOe), 8'h01);
    fixedSupplyOk = 1'b1;
    waitst(4'h8, 500);
    chk(8'({busOkStatus, adjOkStatus, v20OkStatus}), 8'h07);
    chk(8'({hostResetOut, warnOut}), 8'h00);
    $display("supply test done");
  endtask

  task t_wd;
    int n;
    host.service(1'b1, 4'h0);
    step(1000);
    host.service(1'b1, 4'h0);
    step(3150);
    chk(8'({wdEnabled, hostResetOe}), 8'h02);
    n = 3150;
    while (hostResetOe !== 1'b1 && n < 3500) begin
      step(1);
      n++;
    end
    chk(8'(n >= 3190 && n <= 3305), 8'h01);
    chk(8'(hostResetN), 8'h00);
    n = 0;
    while (hostResetOe === 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    chk(8'(n), 8'(`WD_PULSE_CYC));
    step(600);
    host.service(1'b1, 4'h1);
    step(300);
    host.service(1'b1, 4'h1);
    step(2);
    chk(8'(hostResetOe), 8'h01);
    step(260);
    host.service(1'b0, 4'h0);
    step(1);
    chk(8'({wdEnabled, hostResetOe}), 8'h00);
    $display("watchdog test done");
  endtask

  initial begin
    {clockSourceSelect, xtalRunning, extClkRunning, hostClockOutputEnable,
     hostClockRateStrap, busVoltageOk, filterAbove14V,
     filterCapVoltageOk} = 8'h57;
    {fixedSupplyOk, adjustableSupplyOk, twentyVoltSupplyOk, thermalWarning,
     thermalShutdown, shutdownRead, busPartialAllow, triggerEnable} = 8'h60;
    {txRequest, txScheduled, txDone, txCollision} = 4'h0;
    sys_rst = 1'b1;
    step(10);
    sys_rst = 1'b0;
    t_power();
    t_marker();
    t_warn();
    t_thermal();
    t_supply();
    t_wd();
    summarize();
  end
endmodule

// [supervisor_clock_watchdog_consts.vh]
// constants of the supervisor, clock and watchdog block
`ifndef SUPERVISOR_CLOCK_WATCHDOG_CONSTS_VH
`define SUPERVISOR_CLOCK_WATCHDOG_CONSTS_VH

// clock period and time units
`define CLK_PERIOD_PS   4000
`define PS_PER_MS       1000000000
`define MS_CYCLES       (`PS_PER_MS / `CLK_PERIOD_PS)
// one bus bit time at 9600 baud, rounded up to whole cycles
`define BIT_TIME_PS     104166667
`define BIT_CYCLES      ((`BIT_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// times in ms
`define BUS_QUAL_MS     10'd2
`define OSC_DELAY_MS    10'd2
// watchdog reset pulse length in cycles
`define WD_PULSE_CYC    8'hFF

// host clock frequencies in Hz and phase steps of a 32-bit accumulator
`define CLK_HZ          64'd250000000
`define F4_HZ           64'd4000000
`define F8_HZ           64'd8000000
`define F16_HZ          64'd16000000
`define STEP(f)         (((f) * 64'h100000000) / `CLK_HZ)

// host clock source select codes
`define HCLK_OFF        2'h0
`define HCLK_SLOW       2'h1
`define HCLK_FAST       2'h2

// reset values
`define WD_SEL_RST      4'h0

`endif

// [supervisor_clock_watchdog_monitor.sv]
// concurrent checks on the supervisor, clock and watchdog ports
`timescale 1ns/1ps

module supervisor_clock_watchdog_monitor (
  input wire       clk,                   // main clock
  input wire       sys_rst,               // async reset
  input wire       hostClockOutputEnable, // clock enable bit
  input wire       filterAbove14V,        // filter above 14 V
  input wire       filterCapVoltageOk,    // filter above 12 V
  input wire       fixedSupplyOk,         // fixed supply good
  input wire       adjustableSupplyOk,    // adjustable good
  input wire       twentyVoltSupplyOk,    // 20 V good
  input wire       thermalWarning,        // warning level
  input wire       thermalShutdown,       // shutdown level
  input wire       txRequest,             // frame ready
  input wire       txScheduled,           // scheduled frame
  input wire       txDone,                // frame complete
  input wire       txCollision,           // collision
  input wire       hostClockOutput,       // host clock
  input wire       transmitMarkerOut,     // marker pin
  input wire       txGo,                  // start pulse
  input wire       hostResetOe,           // reset pulled low
  input wire       warnOe,                // warning pulled low
  input wire       busOkStatus,           // bus status
  input wire       oscStatus,             // oscillator status
  input wire       shutdownLatched,       // shutdown latch
  input wire [3:0] stateOut               // one-hot state
);
  default clocking mc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_reset_hold: assert property (stateOut[0] || stateOut[1]
    || !fixedSupplyOk || thermalShutdown |-> hostResetOe)
    else $error("host reset released too early");
  a_filter_reset: assert property (!filterCapVoltageOk |-> hostResetOe)
    else $error("low filter without host reset");
  a_warn_fast: assert property (!filterAbove14V || thermalWarning
    |-> warnOe)
    else $error("warning not pulled at once");
  a_normal_good: assert property (stateOut == 4'h4 && !(oscStatus
    && busOkStatus && adjustableSupplyOk && twentyVoltSupplyOk
    && filterCapVoltageOk && !thermalWarning && !thermalShutdown)
    |=> stateOut != 4'h8)
    else $error("normal entered while not all good");
  a_normal_warn: assert property (stateOut == 4'h8 && filterAbove14V
    && !thermalWarning |-> !warnOe)
    else $error("warning held in normal");
  a_shutdown_enter: assert property (thermalShutdown
    |=> stateOut == 4'h1 && shutdownLatched)
    else $error("shutdown did not force reset");
  a_marker_fall: assert property (transmitMarkerOut
    && (txDone || txCollision) |=> !transmitMarkerOut)
    else $error("marker did not fall");
  a_unsched_go: assert property (txRequest && !txScheduled
    && !transmitMarkerOut && !txDone && !txCollision |=> txGo)
    else $error("unscheduled frame not started");
  a_clock_gated: assert property (!hostClockOutputEnable
    ##1 !hostClockOutputEnable |-> !hostClockOutput)
    else $error("host clock runs while disabled");
  a_wd_pulse: assert property ($rose(hostResetOe) && fixedSupplyOk
    && (stateOut[2] || stateOut[3]) && filterCapVoltageOk
    && !thermalShutdown |-> hostResetOe [*8])
    else $error("watchdog reset pulse too short");

  c_normal: cover property (stateOut == 4'h8);
  c_lead: cover property (transmitMarkerOut && txGo);
  c_wd: cover property ($rose(hostResetOe) && stateOut[3]);
  c_latch: cover property (shutdownLatched && !thermalShutdown);
endmodule

bind supervisor_clock_watchdog supervisor_clock_watchdog_monitor mon (.*);
